// File: inc/sfb_pkg.sv
// Constants and types of the serial frame format and baud configuration block
package sfb_pkg;

  // Register addresses on the I/O port
  localparam logic [1:0] ADDR_SHARED    = 2'h0;
  localparam logic [1:0] ADDR_DIV_LOW   = 2'h1;
  localparam logic [1:0] ADDR_CTRL_B    = 2'h2;
  localparam logic [1:0] ADDR_STATUS_A  = 2'h3;

  // Field positions in the shared location
  localparam int SEL_BIT     = 7;
  localparam int MODE_BIT    = 6;
  localparam int PAR_HI_BIT  = 5;
  localparam int PAR_LO_BIT  = 4;
  localparam int STOP_BIT    = 3;
  localparam int SIZE_HI_BIT = 2;
  localparam int SIZE_LO_BIT = 1;
  localparam int POL_BIT     = 0;

  // Field positions in control b and status a
  localparam int SIZE_TOP_BIT  = 2;
  localparam int DBL_BIT       = 1;
  localparam int PERR_BIT      = 2;

  // Reset values
  localparam logic [7:0] FMT_RESET    = 8'h06;
  localparam logic [3:0] DIVH_RESET   = 4'h0;
  localparam logic [7:0] DIVL_RESET   = 8'h00;

  // Divider ratios
  localparam logic [4:0] RATIO_NORMAL = 5'h10;
  localparam logic [4:0] RATIO_DOUBLE = 5'h08;

  typedef enum logic [1:0] {
    sfb_par_off_type_e, sfb_par_rsv_type_e, sfb_par_even_type_e, sfb_par_odd_type_e
  } sfb_parity_type;

  // Decoded configuration handed to the serial engines
  typedef struct packed {
    logic           sync_mode;
    sfb_parity_type parity;
    logic           two_stop;
    logic [3:0]     data_bits;
    logic           clk_pol;
    logic           double_speed;
  } sfb_cfg_type;

  // Processor I/O access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } sfb_io_type;

endpackage

// File: src/sfb_baud_gen.sv
// Baud tick generator fed by the 12-bit divisor
`timescale 1ns/100ps
module sfb_baud_gen (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic [11:0] baud_divisor_value,
  input  wire logic        reload,
  input  wire logic        sync_mode,
  input  wire logic        double_speed,
  // Output
  output logic             bit_tick
);

  logic [11:0] presc;
  logic [4:0]  sub;
  logic [4:0]  ratio;

  // Ratio 16 normal, 8 doubled, sync uses 2
  always_comb begin
    if (sync_mode) begin
      ratio = 5'h02;
    end else if (double_speed) begin
      ratio = sfb_pkg::RATIO_DOUBLE;
    end else begin
      ratio = sfb_pkg::RATIO_NORMAL;
    end
  end

  // Prescaler counts divisor down to zero, then sub counter ratio steps
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      presc    <= 12'h000;
      sub      <= 5'h00;
      bit_tick <= 1'b0;
    end else if (reload) begin
      presc    <= baud_divisor_value;
      sub      <= 5'h00;
      bit_tick <= 1'b0;
    end else if (presc != 12'h000) begin
      presc    <= presc - 12'h001;
      bit_tick <= 1'b0;
    end else begin
      presc <= baud_divisor_value;
      if (sub == ratio - 5'h01) begin
        sub      <= 5'h00;
        bit_tick <= 1'b1;
      end else begin
        sub      <= sub + 5'h01;
        bit_tick <= 1'b0;
      end
    end
  end

  // Tick spacing check in asynchronous mode, normal and double speed
  logic [16:0] gap;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || reload || bit_tick) begin
      gap <= 17'h00000;
    end else begin
      gap <= gap + 17'h00001;
    end
  end

  a_tick_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bit_tick && !$past(reload) && !sync_mode && $stable(baud_divisor_value)
      |-> $past(gap) + 17'h1 <= 17'((baud_divisor_value + 1) * ratio))
    else $error("bit tick came late");

  a_reload_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reload |=> !bit_tick && presc == $past(baud_divisor_value))
    else $error("prescaler not reloaded");

endmodule

// File: src/sfb_cfg_decode.sv
// Decodes raw format bits into the engine configuration
`timescale 1ns/100ps
module sfb_cfg_decode (
  // Raw fields
  input  wire logic [7:0]  fmt,
  input  wire logic        size_top,
  input  wire logic        dbl,
  // Decoded
  output sfb_pkg::sfb_cfg_type cfg,
  output logic             size_reserved
);

  logic [2:0] code;

  // Character size, parity, stop and clock fields
  always_comb begin
    code           = {size_top, fmt[sfb_pkg::SIZE_HI_BIT:sfb_pkg::SIZE_LO_BIT]};
    cfg.sync_mode  = fmt[sfb_pkg::MODE_BIT];
    cfg.parity     = sfb_pkg::sfb_parity_type'(fmt[sfb_pkg::PAR_HI_BIT:sfb_pkg::PAR_LO_BIT]);
    cfg.two_stop   = fmt[sfb_pkg::STOP_BIT];
    cfg.clk_pol    = fmt[sfb_pkg::POL_BIT];
    cfg.double_speed = dbl & ~fmt[sfb_pkg::MODE_BIT];
    size_reserved  = 1'b0;
    if (code == 3'h7) begin
      cfg.data_bits = 4'h9;
    end else if (code[2]) begin
      cfg.data_bits = 4'h8;
      size_reserved = 1'b1;
    end else begin
      cfg.data_bits = 4'h5 + {2'h0, code[1:0]};
    end
  end

endmodule

// File: src/sfb_top.sv
// Frame format and baud register file with parity and clock-edge helpers
`timescale 1ns/100ps
module sfb_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Processor I/O port
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [1:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  // Transmit engine side
  input  wire logic [8:0]  tx_data,
  output logic [8:0]       tx_data_masked,
  output logic             tx_parity_bit,
  output logic             tx_parity_en,
  output logic [1:0]       tx_stop_bits,
  // Receive engine side
  input  wire logic [8:0]  rx_data,
  input  wire logic        rx_parity_bit,
  input  wire logic        rx_frame_done,
  output logic [8:0]       rx_data_masked,
  // Synchronous serial clock, sampled
  input  wire logic        sync_serial_clock,
  output logic             tx_change_strobe,
  output logic             rx_sample_strobe,
  // Configuration out
  output sfb_pkg::sfb_cfg_type cfg,
  output logic [11:0]      baud_divisor_value,
  output logic             bit_tick,
  output logic             parity_error_flag
);

  logic [7:0]  fmt;
  logic [3:0]  div_high;
  logic [7:0]  div_low;
  logic        size_top;
  logic        dbl;
  logic        reload;
  logic        reload_q;
  logic        size_reserved;
  logic        shared_location_select;
  logic [8:0]  data_mask;
  logic        rx_par_calc;
  logic        rx_mismatch;
  logic        sck_q;
  logic        sck_rise;
  logic        sck_fall;

  assign shared_location_select = io_wdata[sfb_pkg::SEL_BIT];
  assign baud_divisor_value     = {div_high, div_low};
  assign reload = io_wr && io_addr == sfb_pkg::ADDR_DIV_LOW;

  // Shared location write routed by select bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fmt      <= sfb_pkg::FMT_RESET;
      div_high <= sfb_pkg::DIVH_RESET;
    end else if (io_wr && io_addr == sfb_pkg::ADDR_SHARED) begin
      if (shared_location_select) begin
        fmt <= io_wdata;
      end else begin
        div_high <= io_wdata[3:0];
      end
    end
  end

  // Low divisor register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_low <= sfb_pkg::DIVL_RESET;
    end else if (reload) begin
      div_low <= io_wdata;
    end
  end

  // Prescaler reload one cycle late, so it sees the new low byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= reload;
    end
  end

  // Bits owned here: size top in control b, double speed in status a
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      size_top <= 1'b0;
      dbl      <= 1'b0;
    end else if (io_wr && io_addr == sfb_pkg::ADDR_CTRL_B) begin
      size_top <= io_wdata[sfb_pkg::SIZE_TOP_BIT];
    end else if (io_wr && io_addr == sfb_pkg::ADDR_STATUS_A) begin
      dbl <= io_wdata[sfb_pkg::DBL_BIT];
    end
  end

  // Read alternates: frame format on a read directly after a read there
  logic prev_shared_rd;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_shared_rd <= 1'b0;
    end else begin
      prev_shared_rd <= io_rd && io_addr == sfb_pkg::ADDR_SHARED && !prev_shared_rd;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == sfb_pkg::ADDR_SHARED) begin
        if (prev_shared_rd) begin
          io_rdata <= {1'b1, fmt[6:0]};
        end else begin
          io_rdata <= {4'h0, div_high};
        end
      end else if (io_addr == sfb_pkg::ADDR_DIV_LOW) begin
        io_rdata <= div_low;
      end else if (io_addr == sfb_pkg::ADDR_CTRL_B) begin
        io_rdata <= {5'h00, size_top, 2'h0};
      end else begin
        io_rdata <= {5'h00, parity_error_flag, dbl, 1'b0};
      end
    end
  end

  sfb_cfg_decode u_dec (
    .fmt           (fmt),
    .size_top      (size_top),
    .dbl           (dbl),
    .cfg           (cfg),
    .size_reserved (size_reserved)
  );

  sfb_baud_gen u_baud (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .baud_divisor_value (baud_divisor_value),
    .reload             (reload_q),
    .sync_mode          (cfg.sync_mode),
    .double_speed       (cfg.double_speed),
    .bit_tick           (bit_tick)
  );

  // Data bit mask for the character size
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_mask
      assign data_mask[gi] = (gi < cfg.data_bits);
    end
  endgenerate

  // Transmit side: masked data, parity and stop count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_data_masked <= 9'h000;
      tx_parity_bit  <= 1'b0;
      tx_parity_en   <= 1'b0;
      tx_stop_bits   <= 2'h1;
    end else begin
      tx_data_masked <= tx_data & data_mask;
      tx_parity_bit  <= ^(tx_data & data_mask) ^ cfg.parity[0];
      tx_parity_en   <= cfg.parity[1];
      tx_stop_bits   <= cfg.two_stop ? 2'h2 : 2'h1;
    end
  end

  // Receive side: masked data and parity check
  assign rx_par_calc = ^(rx_data & data_mask) ^ cfg.parity[0];
  assign rx_mismatch = cfg.parity[1] && (rx_par_calc != rx_parity_bit);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_data_masked    <= 9'h000;
      parity_error_flag <= 1'b0;
    end else if (rx_frame_done) begin
      rx_data_masked    <= rx_data & data_mask;
      parity_error_flag <= rx_mismatch;
    end
  end

  // Serial clock edge strobes with polarity select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sync_serial_clock;
    end
  end
  assign sck_rise = sync_serial_clock && !sck_q;
  assign sck_fall = !sync_serial_clock && sck_q;
  assign tx_change_strobe = cfg.sync_mode && (cfg.clk_pol ? sck_fall : sck_rise);
  assign rx_sample_strobe = cfg.sync_mode && (cfg.clk_pol ? sck_rise : sck_fall);

  a_fmt_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_wr && io_addr == sfb_pkg::ADDR_SHARED && io_wdata[7] |=> fmt == $past(io_wdata)
      && div_high == $past(div_high))
    else $error("frame format write misrouted");

  a_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_wr && io_addr == sfb_pkg::ADDR_SHARED && !io_wdata[7] |=> div_high == $past(io_wdata[3:0])
      && fmt == $past(fmt))
    else $error("divisor high write misrouted");

  a_fmt_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_rd && io_addr == sfb_pkg::ADDR_SHARED && prev_shared_rd |=> io_rdata[7])
    else $error("frame format read without select bit");

  a_high_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_rd && io_addr == sfb_pkg::ADDR_SHARED && !prev_shared_rd |=> io_rdata[7:4] == 4'h0)
    else $error("divisor high read with select bit");

  a_par_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_done |=> parity_error_flag == $past(rx_mismatch))
    else $error("parity error flag wrong");

  a_tx_parity: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 tx_parity_en |-> (^tx_data_masked ^ tx_parity_bit) == $past(cfg.parity[0]))
    else $error("transmit parity wrong");

  a_stop_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(cfg.two_stop) |-> tx_stop_bits == 2'h2)
    else $error("stop count wrong");

  a_edge_async: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.sync_mode |-> !tx_change_strobe && !rx_sample_strobe)
    else $error("edge strobe in async mode");

  a_rx_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_done && cfg.data_bits == 4'h5 |=> rx_data_masked[8:5] == 4'h0)
    else $error("upper receive bits not zero");

endmodule

// File: sim/sfb_partner_model.sv
// Remote serial transceiver model on the receive side and sync clock
`timescale 1ns/100ps
module sfb_partner_model (
  // Clock
  input  wire logic clk_sys,
  // Lines toward the block
  output logic       sync_serial_clock,
  output logic [8:0] rx_data,
  output logic       rx_parity_bit,
  output logic       rx_frame_done
);
  // Idle: clock still and low, data scrambled
  initial begin
    sync_serial_clock = 1'b0;
    rx_data = 9'h155;
    rx_parity_bit = 1'b0;
    rx_frame_done = 1'b0;
  end

  // One character, dirty upper bits, parity right or wrong on command
  task automatic send(input logic [8:0] d, input int nb, input logic odd, input logic bad);
    logic p;
    p = odd ^ bad;
    for (int i = 0; i < nb; i++) p ^= d[i];
    @(negedge clk_sys);
    rx_data = d;
    rx_parity_bit = p;
    rx_frame_done = 1'b1;
    @(negedge clk_sys);
    rx_frame_done = 1'b0;
    rx_data = ~d;
    rx_parity_bit = ~p;
  endtask

  // Burst of serial clock periods, still between bursts
  task automatic burst(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      sync_serial_clock = 1'b1;
      repeat (3) @(negedge clk_sys);
      sync_serial_clock = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
  endtask
endmodule

// File: sim/serial_frame_format_and_baud_config_bench.sv
// Self-checking bench for the frame format and baud configuration block
`timescale 1ns/100ps
module serial_frame_format_and_baud_config_bench;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  sfb_pkg::sfb_io_type  io = '0;
  logic [8:0]           tx_data = 9'h000;
  logic [7:0]           io_rdata;
  logic [8:0]           tx_data_masked, rx_data, rx_data_masked;
  logic [1:0]           tx_stop_bits;
  logic                 tx_parity_bit, tx_parity_en, rx_parity_bit, rx_frame_done;
  logic                 sync_serial_clock, tx_change_strobe, rx_sample_strobe;
  logic                 bit_tick, parity_error_flag;
  logic [11:0]          baud_divisor_value;
  sfb_pkg::sfb_cfg_type cfg;
  int                   n_fail = 0;
  int                   total_checks = 0;
  int                   tx_n, tx_hi, rx_n, rx_hi;

  // Clock
  always #4 clk_sys = ~clk_sys;

  sfb_top u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_wr(io.wr), .io_rd(io.rd),
    .io_addr(io.addr), .io_wdata(io.wdata), .io_rdata(io_rdata), .tx_data(tx_data),
    .tx_data_masked(tx_data_masked), .tx_parity_bit(tx_parity_bit),
    .tx_parity_en(tx_parity_en), .tx_stop_bits(tx_stop_bits), .rx_data(rx_data),
    .rx_parity_bit(rx_parity_bit), .rx_frame_done(rx_frame_done),
    .rx_data_masked(rx_data_masked), .sync_serial_clock(sync_serial_clock),
    .tx_change_strobe(tx_change_strobe), .rx_sample_strobe(rx_sample_strobe),
    .cfg(cfg), .baud_divisor_value(baud_divisor_value), .bit_tick(bit_tick),
    .parity_error_flag(parity_error_flag));

  sfb_partner_model u_partner (
    .clk_sys(clk_sys), .sync_serial_clock(sync_serial_clock), .rx_data(rx_data),
    .rx_parity_bit(rx_parity_bit), .rx_frame_done(rx_frame_done));

  // Strobe counters, level of the serial clock at each strobe
  always @(posedge clk_sys) begin
    if (tx_change_strobe === 1'b1) begin
      tx_n++;
      tx_hi += int'(sync_serial_clock);
    end
    if (rx_sample_strobe === 1'b1) begin
      rx_n++;
      rx_hi += int'(sync_serial_clock);
    end
  end

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    io.wr = 1'b0;
  endtask

  // Read; with two set, a back-to-back pair on one address
  task automatic rd(input logic [1:0] a, input bit two, output logic [7:0] d1,
                    output logic [7:0] d2);
    @(negedge clk_sys);
    io.rd = 1'b1;
    io.addr = a;
    @(negedge clk_sys);
    d1 = io_rdata;
    if (two) @(negedge clk_sys);
    io.rd = 1'b0;
    d2 = io_rdata;
  endtask

  function automatic logic parity(input logic [8:0] d, input int nb, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < nb; i++) p ^= d[i];
    return p;
  endfunction

  // Waits for a tick, then times one full bit period
  task automatic tick_period(input int exp);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (bit_tick !== 1'b1 && n < exp + 4);
    chk("first tick", 12'(n <= exp + 1), 12'h001);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (bit_tick !== 1'b1 && n < exp + 4);
    chk("bit period", 12'(n), 12'(exp));
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [7:0] d1, d2, fmt;
    logic [8:0] dat, mask;
    logic [11:0] div;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [1:0] pars [3] = '{2'h0, 2'h2, 2'h3};
    logic stop, bad;
    int nb, dv;
    void'($urandom(32'he57513b5));
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(sfb_pkg::ADDR_SHARED, 1'b1, d1, d2);
    chk("div high reset", 12'(d1), 12'h000);
    chk("format reset", 12'(d2), 12'({1'b1, sfb_pkg::FMT_RESET[6:0]}));
    $display("test reset done");
    repeat (4) begin
      div = 12'($urandom());
      wr(sfb_pkg::ADDR_SHARED, {4'h0, div[11:8]});
      wr(sfb_pkg::ADDR_DIV_LOW, div[7:0]);
      chk("divisor", baud_divisor_value, div);
      chk("format kept", 12'(cfg.data_bits), 12'h008);
      rd(sfb_pkg::ADDR_SHARED, 1'b0, d1, d2);
      chk("div high read", 12'(d2), 12'(div[11:8]));
    end
    $display("test divisor done");
    foreach (codes[k]) for (int pi = 0; pi < 3; pi++) begin
      stop = 1'($urandom());
      nb = codes[k][2] ? 9 : 5 + int'(codes[k][1:0]);
      mask = 9'((1 << nb) - 1);
      fmt = {2'b10, pars[pi], stop, codes[k][1:0], 1'b0};
      wr(sfb_pkg::ADDR_CTRL_B, {5'h00, codes[k][2], 2'h0});
      wr(sfb_pkg::ADDR_SHARED, fmt);
      @(negedge clk_sys);
      chk("parity field", 12'(cfg.parity), 12'(pars[pi]));
      chk("char size", 12'(cfg.data_bits), 12'(nb));
      chk("stop count", 12'(tx_stop_bits), 12'(stop + 1));
      chk("parity on", 12'(tx_parity_en), 12'(pars[pi][1]));
      dat = 9'($urandom());
      tx_data = dat;
      @(negedge clk_sys);
      chk("tx masked", 12'(tx_data_masked), 12'(dat & mask));
      if (pars[pi][1])
        chk("tx parity", 12'(tx_parity_bit), 12'(parity(dat, nb, pars[pi][0])));
      bad = 1'($urandom());
      u_partner.send(dat, nb, pars[pi][0], bad);
      chk("rx masked", 12'(rx_data_masked), 12'(dat & mask));
      chk("parity error", 12'(parity_error_flag), 12'(pars[pi][1] & bad));
    end
    rd(sfb_pkg::ADDR_SHARED, 1'b1, d1, d2);
    chk("format read", 12'(d2), 12'(fmt));
    chk("divisor kept", baud_divisor_value, div);
    $display("test format done");
    for (int m = 0; m < 3; m++) begin
      dv = $urandom_range(0, 7);
      wr(sfb_pkg::ADDR_SHARED, {1'b1, 1'(m == 2), 6'h06});
      wr(sfb_pkg::ADDR_STATUS_A, {6'h00, 1'(m == 1), 1'b0});
      wr(sfb_pkg::ADDR_SHARED, 8'h00);
      wr(sfb_pkg::ADDR_DIV_LOW, 8'(dv));
      tick_period((dv + 1) * (m == 2 ? 2 : m == 1 ? int'(sfb_pkg::RATIO_DOUBLE) :
                  int'(sfb_pkg::RATIO_NORMAL)));
    end
    $display("test baud done");
    for (int p = 0; p < 3; p++) begin
      wr(sfb_pkg::ADDR_SHARED, {1'b1, 1'(p < 2), 5'h03, 1'(p == 1)});
      tx_n = 0;
      tx_hi = 0;
      rx_n = 0;
      rx_hi = 0;
      u_partner.burst(3);
      chk("tx edges", 12'(tx_n), 12'(p < 2 ? 3 : 0));
      chk("tx rising", 12'(tx_hi), 12'(p == 0 ? 3 : 0));
      chk("rx edges", 12'(rx_n), 12'(p < 2 ? 3 : 0));
      chk("rx rising", 12'(rx_hi), 12'(p == 1 ? 3 : 0));
    end
    $display("test sync clock done");
    final_report();
  end
endmodule
